// >>> design/gpio_port.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defs.svh"
module gpio_port
   import gpio_port_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] addr,
   input  wire word_t      wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  word_t      rdata,
   input  wire pin_bits_t  pad_in,
   output var  pin_bits_t  pad_out,
   output var  pin_bits_t  pad_oe,
   output var  pin_bits_t  pad_pull_up,
   output var  pin_bits_t  pad_pull_down,
   input  wire logic       stop_mode,
   input  wire logic       stop_pin_drive_keep,
   input  wire logic       transmit_data_ch0,
   input  wire logic       serial_clock_out_ch0,
   input  wire logic       serial_clock_oe_ch0,
   input  wire logic       i2c_clock_out,
   input  wire logic       i2c_clock_oe,
   output var  logic       receive_data_ch0,
   output var  logic       serial_clock_ch0,
   output var  logic       clear_to_send_ch0,
   output var  logic       timer_capture_in,
   output var  pin_bits_t  encoder_in,
   output var  logic       ext_interrupt,
   output var  logic       i2c_clock_in
);
   pin_bits_t pin_data_reg;
   pin_bits_t output_enable_reg;
   pin_bits_t function_select_1_reg;
   pin_bits_t function_select_2_reg;
   pin_bits_t function_select_3_reg;
   pin_bits_t function_select_4_reg;
   pin_bits_t function_select_5_reg;
   pin_bits_t open_drain_reg;
   pin_bits_t pull_up_reg;
   pin_bits_t pull_down_reg;
   pin_bits_t input_enable_reg;
   pin_bits_t pin_level;
   pin_bits_t gated_in;
   pin_bits_t port_mode;
   pin_bits_t func_oe;
   pin_bits_t func_out;
   reg_sel_t  wsel;
   reg_sel_t  rsel;
   word_t     next_rdata;

   function automatic reg_sel_t decode(input logic [7:0] a);
      unique case (a)
         `OFF_PIN_DATA:      decode = sel_data;
         `OFF_OUTPUT_ENABLE: decode = sel_oe;
         `OFF_FUNC_SEL_1:    decode = sel_fs1;
         `OFF_FUNC_SEL_2:    decode = sel_fs2;
         `OFF_FUNC_SEL_3:    decode = sel_fs3;
         `OFF_FUNC_SEL_4:    decode = sel_fs4;
         `OFF_FUNC_SEL_5:    decode = sel_fs5;
         `OFF_OPEN_DRAIN:    decode = sel_od;
         `OFF_PULL_UP:       decode = sel_pu;
         `OFF_PULL_DOWN:     decode = sel_pd;
         `OFF_INPUT_ENABLE:  decode = sel_ie;
         default:            decode = sel_none;
      endcase
   endfunction : decode

   assign wsel = wr ? decode(addr) : sel_none;
   assign rsel = decode(addr);

   pin_sync u_sync
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (pad_in),
      .sync_out (pin_level)
   );

   // register writes, unimplemented function bits held at zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_data_reg          <= `RESET_PIN_BITS;
         output_enable_reg     <= `RESET_PIN_BITS;
         function_select_1_reg <= `RESET_PIN_BITS;
         function_select_2_reg <= `RESET_PIN_BITS;
         function_select_3_reg <= `RESET_PIN_BITS;
         function_select_4_reg <= `RESET_PIN_BITS;
         function_select_5_reg <= `RESET_PIN_BITS;
         open_drain_reg        <= `RESET_PIN_BITS;
         pull_up_reg           <= `RESET_PIN_BITS;
         pull_down_reg         <= `RESET_PIN_BITS;
         input_enable_reg      <= `RESET_PIN_BITS;
      end
      else
      begin
         unique case (wsel)
            sel_data: pin_data_reg          <= wdata[2:0];
            sel_oe:   output_enable_reg     <= wdata[2:0];
            sel_fs1:  function_select_1_reg <= wdata[2:0] & `FS1_MASK;
            sel_fs2:  function_select_2_reg <= wdata[2:0] & `FS2_MASK;
            sel_fs3:  function_select_3_reg <= wdata[2:0] & `FS3_MASK;
            sel_fs4:  function_select_4_reg <= wdata[2:0] & `FS4_MASK;
            sel_fs5:  function_select_5_reg <= wdata[2:0] & `FS5_MASK;
            sel_od:   open_drain_reg        <= wdata[2:0];
            sel_pu:   pull_up_reg           <= wdata[2:0];
            sel_pd:   pull_down_reg         <= wdata[2:0];
            sel_ie:   input_enable_reg      <= wdata[2:0];
            default:  ;
         endcase
      end
   end

   assign gated_in = pin_level & input_enable_reg;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (rsel)
         sel_data: next_rdata[2:0] = gated_in;
         sel_oe:   next_rdata[2:0] = output_enable_reg;
         sel_fs1:  next_rdata[2:0] = function_select_1_reg;
         sel_fs2:  next_rdata[2:0] = function_select_2_reg;
         sel_fs3:  next_rdata[2:0] = function_select_3_reg;
         sel_fs4:  next_rdata[2:0] = function_select_4_reg;
         sel_fs5:  next_rdata[2:0] = function_select_5_reg;
         sel_od:   next_rdata[2:0] = open_drain_reg;
         sel_pu:   next_rdata[2:0] = pull_up_reg;
         sel_pd:   next_rdata[2:0] = pull_down_reg;
         sel_ie:   next_rdata[2:0] = input_enable_reg;
         default:  next_rdata = 32'h0000_0000;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 32'h0000_0000;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= 32'h0000_0000;
   end

   // function mux, outputs: pin0 transmit, pin2 serial clock or i2c clock
   always_comb
   begin
      port_mode = ~(function_select_1_reg | function_select_2_reg
                  | function_select_3_reg | function_select_4_reg
                  | function_select_5_reg);
      func_oe   = 3'h0;
      func_out  = 3'h0;
      func_oe[0]  = function_select_1_reg[0];
      func_out[0] = transmit_data_ch0;
      if (function_select_1_reg[2])
      begin
         func_oe[2]  = serial_clock_oe_ch0;
         func_out[2] = serial_clock_out_ch0;
      end
      else if (function_select_5_reg[2])
      begin
         func_oe[2]  = i2c_clock_oe;
         func_out[2] = i2c_clock_out;
      end
   end

   genvar i;
   generate
      for (i = 0; i < `PIN_COUNT; i++)
      begin : g_pin
         pin_cell u_cell
         (
            .clk             (clk),
            .rst_n           (rst_n),
            .port_mode       (port_mode[i]),
            .port_oe         (output_enable_reg[i]),
            .port_data       (pin_data_reg[i]),
            .func_oe         (func_oe[i]),
            .func_out        (func_out[i]),
            .open_drain      (open_drain_reg[i]),
            .stop_mode       (stop_mode),
            .stop_drive_keep (stop_pin_drive_keep),
            .pad_out         (pad_out[i]),
            .pad_oe          (pad_oe[i])
         );
      end
   endgenerate

   // peripheral inputs, zero when not selected
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         receive_data_ch0  <= 1'b0;
         serial_clock_ch0  <= 1'b0;
         clear_to_send_ch0 <= 1'b0;
         timer_capture_in  <= 1'b0;
         encoder_in        <= 3'h0;
         i2c_clock_in      <= 1'b0;
      end
      else
      begin
         receive_data_ch0  <= gated_in[1] & function_select_1_reg[1];
         serial_clock_ch0  <= gated_in[2] & function_select_1_reg[2];
         clear_to_send_ch0 <= gated_in[2] & function_select_2_reg[2];
         timer_capture_in  <= gated_in[1] & function_select_2_reg[1];
         encoder_in        <= gated_in & function_select_3_reg;
         i2c_clock_in      <= gated_in[2] & function_select_5_reg[2];
      end
   end

   // wake interrupt from pin2
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ext_interrupt <= 1'b0;
      else if (stop_mode)
         ext_interrupt <= gated_in[2] & function_select_4_reg[2];
      else
         ext_interrupt <= gated_in[2];
   end

   // pull enables to the pads
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pad_pull_up   <= 3'h0;
         pad_pull_down <= 3'h0;
      end
      else
      begin
         pad_pull_up   <= pull_up_reg;
         pad_pull_down <= pull_down_reg;
      end
   end

   // bus side checks
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rd && decode(addr) == sel_none |=> rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rdata[31:3] == 29'h0)
      else $error("upper read bits not zero");

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !rd |=> rdata == 32'h0000_0000)
      else $error("read data not cleared after strobe");

   a_data_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr && addr == `OFF_PIN_DATA |=> pin_data_reg == $past(wdata[2:0]))
      else $error("data write lost");

   a_oe_readback: assert property (@(posedge clk) disable iff (!rst_n)
      wr && addr == `OFF_OUTPUT_ENABLE ##1 rd && addr == `OFF_OUTPUT_ENABLE
      |=> rdata[2:0] == $past(wdata[2:0], 2))
      else $error("output enable readback wrong");

   a_data_masked: assert property (@(posedge clk) disable iff (!rst_n)
      rd && addr == `OFF_PIN_DATA |=> (rdata[2:0] & ~$past(input_enable_reg)) == 3'h0)
      else $error("disabled input read nonzero");

   a_func_unused: assert property (@(posedge clk) disable iff (!rst_n)
      function_select_2_reg[0] == 1'b0 && function_select_4_reg[1:0] == 2'h0
      && function_select_5_reg[1:0] == 2'h0)
      else $error("unimplemented function bit set");

   // pin side checks
   a_int_stop: assert property (@(posedge clk) disable iff (!rst_n)
      stop_mode && function_select_4_reg[2] && gated_in[2] |=> ext_interrupt)
      else $error("stop wake interrupt lost");

   a_int_run: assert property (@(posedge clk) disable iff (!rst_n)
      !stop_mode |=> ext_interrupt == $past(gated_in[2]))
      else $error("run mode interrupt wrong");

   a_int_off: assert property (@(posedge clk) disable iff (!rst_n)
      !input_enable_reg[2] |=> !ext_interrupt)
      else $error("interrupt from disabled input");

   a_stop_drive_off: assert property (@(posedge clk) disable iff (!rst_n)
      stop_mode && !stop_pin_drive_keep |=> pad_oe == 3'h0)
      else $error("pin driven in stop without keep");

   a_func_not_port: assert property (@(posedge clk) disable iff (!rst_n)
      function_select_3_reg[0] && !function_select_1_reg[0] |=> !pad_oe[0])
      else $error("encoder pin still driven");

   a_tx_route: assert property (@(posedge clk) disable iff (!rst_n)
      function_select_1_reg[0] && !open_drain_reg[0] && !stop_mode
      |=> pad_oe[0] && pad_out[0] == $past(transmit_data_ch0))
      else $error("transmit data not on pin0");

   a_sclk_route: assert property (@(posedge clk) disable iff (!rst_n)
      function_select_1_reg[2] && !open_drain_reg[2] && !stop_mode
      |=> pad_oe[2] == $past(serial_clock_oe_ch0))
      else $error("serial clock enable not on pin2");

   a_rx_gated: assert property (@(posedge clk) disable iff (!rst_n)
      !input_enable_reg[1] |=> !receive_data_ch0)
      else $error("receive input passed while disabled");

   a_pull_follow: assert property (@(posedge clk) disable iff (!rst_n)
      pad_pull_up == $past(pull_up_reg) && pad_pull_down == $past(pull_down_reg))
      else $error("pull enable not following register");

   a_reset_quiet: assert property (@(posedge clk)
      !rst_n |=> pad_oe == 3'h0 && pad_pull_up == 3'h0 && pad_pull_down == 3'h0)
      else $error("pins active after reset");

   generate
      for (i = 0; i < `PIN_COUNT; i++)
      begin : g_pin_check
         a_port_oe_off: assert property (@(posedge clk) disable iff (!rst_n)
            port_mode[i] && !output_enable_reg[i] |=> !pad_oe[i])
            else $error("input pin driven");
         a_enc_route: assert property (@(posedge clk) disable iff (!rst_n)
            function_select_3_reg[i] && input_enable_reg[i]
            |=> encoder_in[i] == $past(pin_level[i]))
            else $error("encoder input not routed");
      end
   endgenerate

   // main scenarios
   c_port_drive: cover property (@(posedge clk) disable iff (!rst_n) pad_oe[0] && pad_out[0]);
   c_int_stop: cover property (@(posedge clk) disable iff (!rst_n) stop_mode && ext_interrupt);
   c_encoder: cover property (@(posedge clk) disable iff (!rst_n) encoder_in == 3'h7);
   c_readback: cover property (@(posedge clk) disable iff (!rst_n) wr ##1 rd);
   c_stop_keep: cover property (@(posedge clk) disable iff (!rst_n)
      stop_mode && stop_pin_drive_keep && pad_oe != 3'h0);
endmodule : gpio_port
`default_nettype wire

// >>> design/gpio_port_defs.svh
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define PIN_COUNT            3
`define REG_ADDR_WIDTH       8
`define OFF_PIN_DATA         8'h00
`define OFF_OUTPUT_ENABLE    8'h04
`define OFF_FUNC_SEL_1       8'h08
`define OFF_FUNC_SEL_2       8'h0c
`define OFF_FUNC_SEL_3       8'h10
`define OFF_FUNC_SEL_4       8'h14
`define OFF_FUNC_SEL_5       8'h18
`define OFF_OPEN_DRAIN       8'h28
`define OFF_PULL_UP          8'h2c
`define OFF_PULL_DOWN        8'h30
`define OFF_INPUT_ENABLE     8'h38
`define RESET_PIN_BITS       3'h0
`define FS1_MASK             3'h7
`define FS2_MASK             3'h6
`define FS3_MASK             3'h7
`define FS4_MASK             3'h4
`define FS5_MASK             3'h4
`define SYNC_STAGES          2

`endif

// >>> design/gpio_port_pkg.sv
package gpio_port_pkg;
   typedef logic [2:0]  pin_bits_t;
   typedef logic [31:0] word_t;
   typedef enum logic [3:0] {
      sel_data    = 4'h0,
      sel_oe      = 4'h1,
      sel_fs1     = 4'h2,
      sel_fs2     = 4'h3,
      sel_fs3     = 4'h4,
      sel_fs4     = 4'h5,
      sel_fs5     = 4'h6,
      sel_od      = 4'h7,
      sel_pu      = 4'h8,
      sel_pd      = 4'h9,
      sel_ie      = 4'ha,
      sel_none    = 4'hf
   } reg_sel_t;
endpackage : gpio_port_pkg

// >>> design/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
   import gpio_port_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire pin_bits_t async_in,
   output var  pin_bits_t sync_out
);
   pin_bits_t stage1;

   // two flops per pin, first stage read only by second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stage1   <= 3'h0;
         sync_out <= 3'h0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : pin_sync
`default_nettype wire

// >>> design/pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
module pin_cell
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic port_mode,
   input  wire logic port_oe,
   input  wire logic port_data,
   input  wire logic func_oe,
   input  wire logic func_out,
   input  wire logic open_drain,
   input  wire logic stop_mode,
   input  wire logic stop_drive_keep,
   output var  logic pad_out,
   output var  logic pad_oe
);
   logic want_oe;
   logic want_val;

   always_comb
   begin
      want_val = port_mode ? port_data : func_out;
      want_oe  = port_mode ? port_oe : func_oe;
      if (open_drain)
      begin
         want_oe  = want_oe & ~want_val;
         want_val = 1'b0;
      end
      if (stop_mode && !stop_drive_keep)
         want_oe = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
      end
      else
      begin
         pad_out <= want_val;
         pad_oe  <= want_oe;
      end
   end

   a_oe_follows_port: assert property (@(posedge clk) disable iff (!rst_n)
      port_mode && port_oe && !open_drain && !stop_mode |=> pad_oe && pad_out == $past(port_data))
      else $error("port pin not driven from data bit");
endmodule : pin_cell
`default_nettype wire

// >>> test/pin_world.sv
`timescale 1ns/10ps
`default_nettype none
module pin_world
   import gpio_port_pkg::*;
(
   input  wire logic      clk,
   input  wire pin_bits_t pad_out,
   input  wire pin_bits_t pad_oe,
   input  wire pin_bits_t pad_pull_up,
   input  wire pin_bits_t pad_pull_down,
   input  wire pin_bits_t ext_drive,
   input  wire pin_bits_t ext_level,
   output var  pin_bits_t pad_in
);
   pin_bits_t float_bits = 3'h0;

   // undriven pins without pull wander every cycle
   always @(posedge clk) float_bits <= ~float_bits;

   // each pin resolved on its own
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_drive[i])
            pad_in[i] = ext_level[i];
         else if (pad_pull_up[i])
            pad_in[i] = 1'b1;
         else if (pad_pull_down[i])
            pad_in[i] = 1'b0;
         else
            pad_in[i] = float_bits[i];
      end
   end
endmodule : pin_world
`default_nettype wire

// >>> test/three_bit_port_with_function_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
module three_bit_port_with_function_mux_tb
   import gpio_port_pkg::*;
;
   logic       clk, rst_n, wr, rd, stop_mode, stop_keep;
   logic [7:0] addr;
   word_t      wdata, rdata;
   pin_bits_t  pad_in, pad_out, pad_oe, pad_pu, pad_pd, ext_drive, ext_level, enc;
   logic       tx, sclk_out, sclk_oe, i2c_out, i2c_oe, rx, sclk_in, cts, tcap, irq, i2c_in;
   logic [7:0] periph;
   int         n_mismatch, total_checks;
   logic [7:0] reg_off [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                                8'h28, 8'h2c, 8'h30, 8'h38, 8'h1c, 8'h3c};
   logic [2:0] reg_mask [13] = '{3'h0, 3'h7, 3'h7, 3'h6, 3'h7, 3'h4, 3'h4,
                                 3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h0};
   logic [7:0] fin_off [8] = '{8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h10, 8'h10, 8'h18};
   int         fin_pin [8] = '{1, 2, 2, 1, 0, 1, 2, 2};

   assign periph = {i2c_in, enc, tcap, cts, sclk_in, rx};

   gpio_port u_gpio_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pu), .pad_pull_down(pad_pd), .stop_mode(stop_mode),
      .stop_pin_drive_keep(stop_keep), .transmit_data_ch0(tx),
      .serial_clock_out_ch0(sclk_out), .serial_clock_oe_ch0(sclk_oe),
      .i2c_clock_out(i2c_out), .i2c_clock_oe(i2c_oe), .receive_data_ch0(rx),
      .serial_clock_ch0(sclk_in), .clear_to_send_ch0(cts), .timer_capture_in(tcap),
      .encoder_in(enc), .ext_interrupt(irq), .i2c_clock_in(i2c_in));

   pin_world u_pin_world (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pu), .pad_pull_down(pad_pd), .ext_drive(ext_drive),
      .ext_level(ext_level), .pad_in(pad_in));

   task check(input word_t seen, input word_t exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task wr_reg(input logic [7:0] a, input word_t d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [7:0] a, input word_t exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rd_chk

   task wr_rd(input logic [7:0] a, input word_t d, input word_t exp);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge clk);
      rd    <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : wr_rd

   task end_of_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end

   initial
   begin
      {rst_n, wr, rd, stop_mode, stop_keep, addr, wdata} = '0;
      {tx, sclk_out, sclk_oe, i2c_out, i2c_oe, ext_drive, ext_level} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check(word_t'({pad_oe, pad_pu, pad_pd}), 32'h0);
      for (int k = 0; k < 13; k++)
         rd_chk(reg_off[k], 32'h0);
      for (int k = 1; k < 13; k++)
      begin
         wr_reg(reg_off[k], 32'hffffffff);
         rd_chk(reg_off[k], word_t'(reg_mask[k]));
         if (reg_off[k] == 8'h2c)
            check(word_t'(pad_pu), 32'h7);
         if (reg_off[k] == 8'h30)
            check(word_t'(pad_pd), 32'h7);
         wr_reg(reg_off[k], 32'h0);
      end
      wr_reg(8'h38, 32'h7);
      wr_reg(8'h04, 32'h7);
      wr_reg(8'h00, 32'hfffffffd);
      repeat (2) @(posedge clk);
      check(word_t'({pad_oe, pad_out}), 32'h3d);
      wr_reg(8'h28, 32'h5);
      repeat (2) @(posedge clk);
      check(word_t'({pad_oe, pad_out}), 32'h10);
      wr_reg(8'h28, 32'h0);
      repeat (4) @(posedge clk);
      rd_chk(8'h00, 32'h5);
      wr_rd(8'h04, 32'hfffffffe, 32'h6);
      wr_reg(8'h04, 32'h0);
      ext_drive <= 3'h7;
      ext_level <= 3'h6;
      wr_reg(8'h38, 32'h3);
      repeat (6) @(posedge clk);
      rd_chk(8'h00, 32'h2);
      wr_reg(8'h38, 32'h7);
      for (int k = 0; k < 8; k++)
      begin
         wr_reg(fin_off[k], word_t'(1) << fin_pin[k]);
         for (int v = 0; v < 2; v++)
         begin
            ext_level <= {3{v[0]}};
            repeat (6) @(posedge clk);
            check(word_t'(periph[k]), word_t'(v));
         end
         wr_reg(fin_off[k], 32'h0);
      end
      wr_reg(8'h08, 32'h5);
      tx       <= 1'b1;
      sclk_oe  <= 1'b1;
      sclk_out <= 1'b1;
      repeat (3) @(posedge clk);
      check(word_t'({pad_oe[2], pad_out[2], pad_out[0]}), 32'h7);
      tx <= 1'b0;
      repeat (3) @(posedge clk);
      check(word_t'(pad_out[0]), 32'h0);
      wr_reg(8'h08, 32'h0);
      wr_reg(8'h18, 32'h4);
      i2c_oe <= 1'b1;
      repeat (3) @(posedge clk);
      check(word_t'(pad_oe[2]), 32'h1);
      wr_reg(8'h18, 32'h0);
      i2c_oe <= 1'b0;
      ext_level <= 3'h7;
      wr_reg(8'h38, 32'h4);
      wr_reg(8'h04, 32'h3);
      repeat (6) @(posedge clk);
      check(word_t'({irq, pad_oe}), 32'hb);
      stop_mode <= 1'b1;
      repeat (6) @(posedge clk);
      check(word_t'({irq, pad_oe}), 32'h0);
      stop_keep <= 1'b1;
      wr_reg(8'h14, 32'h4);
      repeat (6) @(posedge clk);
      check(word_t'({irq, pad_oe}), 32'hb);
      stop_keep <= 1'b0;
      repeat (6) @(posedge clk);
      check(word_t'({irq, pad_oe}), 32'h8);
      stop_mode <= 1'b0;
      wr_reg(8'h38, 32'h0);
      repeat (6) @(posedge clk);
      check(word_t'(irq), 32'h0);
      end_of_test();
   end
endmodule : three_bit_port_with_function_mux_tb
`default_nettype wire
